// *** verilog/kscd_pkg.sv ***
// Constants, types and shared helpers of the keypad scan and display controller
package kscd_pkg;
	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_NS      = 4;
	localparam int INT_NS      = 10000;
	localparam int TICK_CYCLES = INT_NS / CLK_NS;
	localparam int KEY_US      = 80;
	localparam int KEY_TICKS   = KEY_US * 1000 / INT_NS;
	localparam int DIGIT_US    = 640;
	localparam int DIGIT_TICKS = DIGIT_US * 1000 / INT_NS;
	localparam int NK_SCANS    = 2;
	localparam int FIFO_DEPTH  = 8;
	localparam int DISP_MAX    = 16;
	// ------------------------------------------------------------
	// Register map and fields
	// ------------------------------------------------------------
	localparam logic [7:0] A_CTRL  = 8'h00;
	localparam logic [7:0] A_CMD   = 8'h04;
	localparam logic [7:0] A_STAT  = 8'h08;
	localparam logic [7:0] A_DATA  = 8'h0C;
	localparam logic [7:0] A_RSEL  = 8'h10;
	localparam logic [7:0] A_DADDR = 8'h14;
	localparam logic [7:0] CTRL_RST = 8'h08;
	localparam int CTRL_DM  = 3;
	localparam int CTRL_EM  = 5;
	localparam int CMD_CF   = 0;
	localparam int CMD_CD   = 1;
	localparam int CMD_CA   = 2;
	localparam int CMD_EI   = 3;
	localparam int CMD_CODE = 4;
	localparam int RSEL_AI  = 3;
	localparam int DADDR_AI = 4;
	localparam logic [1:0] KM_SENSOR = 2'h2;
	localparam logic [1:0] KM_STROBE = 2'h3;
	localparam logic [3:0] LAST8  = 4'h7;
	localparam logic [3:0] LAST16 = 4'hF;
	localparam logic [7:0] CLR_ZERO  = 8'h00;
	localparam logic [7:0] CLR_SPACE = 8'h20;
	localparam logic [7:0] CLR_ONES  = 8'hFF;
	localparam logic [5:0] KEY_LAST  = 6'h3F;
	localparam logic [2:0] COL_LAST  = 3'h7;
	typedef enum logic [1:0] {TK_IDLE, TK_SKIP, TK_CHECK, TK_HOLD} kscd_tk_t;
	// Address step that wraps at the active display length
	function automatic logic [3:0] wrapInc(input logic [3:0] a, input logic [3:0] last);
		return (a == last) ? 4'h0 : a + 4'h1;
	endfunction : wrapInc
endpackage : kscd_pkg

// *** verilog/kscd_fifo.sv ***
// Eight-entry character queue for key and strobed codes
`timescale 1ns/100ps
module kscd_fifo (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// Fill side
	input  wire logic       push,
	input  wire logic [7:0] pushData,
	// Drain side
	input  wire logic       pop,
	input  wire logic       clr,
	output logic      [7:0] head,
	output logic      [3:0] count,
	output logic            full,
	output logic            empty
);
	logic [7:0] memR [kscd_pkg::FIFO_DEPTH];
	logic [2:0] wrR;
	logic [2:0] rdR;
	logic [3:0] cntR;

	assign head  = memR[rdR];
	assign count = cntR;
	assign full  = cntR == 4'(kscd_pkg::FIFO_DEPTH);
	assign empty = cntR == 4'h0;

	// Caller guards push against full and pop against empty
	always_ff @(posedge clk) begin
		if (rst || clr) begin
			wrR  <= 3'h0;
			rdR  <= 3'h0;
			cntR <= 4'h0;
		end else begin
			wrR  <= wrR + {2'h0, push};
			rdR  <= rdR + {2'h0, pop};
			cntR <= cntR + {3'h0, push} - {3'h0, pop};
		end
	end

	always_ff @(posedge clk) begin
		if (push) begin
			memR[wrR] <= pushData;
		end
	end
endmodule : kscd_fifo

// *** verilog/kscd_disp.sv ***
// Display RAM with left and right entry, clearing and digit scan
`timescale 1ns/100ps
module kscd_disp (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       tick,
	// Mode
	input  wire logic       shortMode,
	input  wire logic       rightEntry,
	// Host side
	input  wire logic       wrStb,
	input  wire logic [3:0] wrAddr,
	input  wire logic [7:0] wrData,
	input  wire logic       clrStb,
	input  wire logic [1:0] clrCode,
	// Display side
	output logic      [3:0] digitR,
	output logic      [7:0] segR,
	output logic            busyR
);
	logic [7:0] ram [kscd_pkg::DISP_MAX];
	logic [5:0] dwellR;
	logic [3:0] lapR;
	logic [3:0] last;
	logic [7:0] fill;
	logic       wrOk;
	logic       stepDig;

	assign last    = shortMode ? kscd_pkg::LAST8 : kscd_pkg::LAST16;
	assign fill    = clrCode[1] ? (clrCode[0] ? kscd_pkg::CLR_ONES : kscd_pkg::CLR_SPACE)
		: kscd_pkg::CLR_ZERO;
	assign wrOk    = wrStb & ~busyR;
	assign stepDig = tick && dwellR == 6'(kscd_pkg::DIGIT_TICKS - 1);

	// ------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------
	for (genvar i = 0; i < kscd_pkg::DISP_MAX; i++) begin : gEnt
		always_ff @(posedge clk) begin
			if (rst) begin
				ram[i] <= kscd_pkg::CLR_ZERO;
			end else if (clrStb) begin
				ram[i] <= fill;
			end else if (wrOk && rightEntry) begin
				if (4'(i) == last) begin
					ram[i] <= wrData;
				end else if (4'(i) < last) begin
					ram[i] <= ram[(i + 1) % kscd_pkg::DISP_MAX];
				end
			end else if (wrOk && wrAddr == 4'(i)) begin
				ram[i] <= wrData;
			end
		end
	end

	// ------------------------------------------------------------
	// Digit scan; eight digits keep the same dwell, so duty doubles
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			dwellR <= 6'h00;
			digitR <= 4'h0;
			segR   <= kscd_pkg::CLR_ZERO;
			busyR  <= 1'b0;
			lapR   <= 4'h0;
		end else begin
			segR <= ram[digitR];
			if (tick) begin
				dwellR <= stepDig ? 6'h00 : dwellR + 6'h01;
			end
			if (stepDig) begin
				digitR <= kscd_pkg::wrapInc(digitR, last);
			end
			// Busy for one full lap, so a clear issued late in a scan is not cut short
			if (clrStb) begin
				busyR <= 1'b1;
				lapR  <= digitR;
			end else if (stepDig && kscd_pkg::wrapInc(digitR, last) == lapR) begin
				busyR <= 1'b0;
			end
		end
	end

	chk_clear_busy: assert property (@(posedge clk) disable iff (rst)
		clrStb |=> busyR ##1 busyR) else $error("display not held busy while clearing");
endmodule : kscd_disp

// *** verilog/kscd_keypad_ctrl.sv ***
// Keyboard, sensor and display scanning core with an APB register port
// Operation
// - Two-key: after closure skip one scan, then queue if no other key closed
// - Queuing into an empty queue raises the event request
// - Validated key with queue full is dropped and overrun flag set
// - Two-key: hold while others closed; drop on early release; queue once
// - Two-key simultaneous closures wait until one key stays alone
// - N-key: wait two scans after detection, queue if still closed
// - N-key: simultaneous keys queue in scan order
// - Error mode: two new keys in one debounce set error, block, raise event
// - Error flag holds until clear command with queue-clear bit one
// - Sensor mode copies return lines to the scanned row, no debounce
// - Sensor mode raises event on any change at scan end
// - Sensor event cleared by data read or end-interrupt per auto-step
// - Key byte: ctrl, shift, row, column from top bit down
// - Strobed mode queues return lines on strobe rising edge
// - Left entry: address zero leftmost, wraps after last position
// - Right entry shifts left and writes the rightmost position
// - Auto-step advances the display address per write, else holds
// - Eight-digit mode scans in half the time of sixteen
// - Status shows count, overrun on full write, underrun on empty read
// - Status shows display unavailable until clearing completes
// - Sensor/error bit: any sensor closure, or the error flag
// - Queue-clear empties queue, drops event, sensor row to zero
// - Each queue read advances unless an error occurs
//
// The APB interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/100ps
module kscd_keypad_ctrl #(
	parameter int TICK_CYCLES = kscd_pkg::TICK_CYCLES
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Matrix pins
	input  wire logic [7:0]  returnLines,
	input  wire logic        shiftIn,
	input  wire logic        strobe_modifier_pin,
	output logic      [2:0]  scanLines,
	// Display and host event
	output logic      [3:0]  dispDigit,
	output logic      [7:0]  dispData,
	output logic             eventReq
);
	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	logic [11:0]  prescR;
	logic         tickR;
	logic [2:0]   keyTickR;
	logic [5:0]   keyPosR;
	logic [7:0]   retS1;
	logic [7:0]   retS2;
	logic         shfS1;
	logic         shfS2;
	logic         stbS1;
	logic         stbS2;
	logic         stbS3;
	logic [7:0]   ctrlR;
	logic [3:0]   rselR;
	logic [3:0]   dAddrR;
	logic         dAiR;
	logic [63:0]  sensRamR;
	logic         sensLockR;
	logic         sensChgR;
	logic [63:0]  pendR;
	logic [63:0]  doneR;
	logic [127:0] waitR;
	kscd_pkg::kscd_tk_t tkR;
	logic [5:0]   candR;
	logic         otherR;
	logic         errLatchR;
	logic         overR;
	logic         underR;
	logic         eventReqR;
	logic [31:0]  prdataR;
	logic         preadyR;
	logic         pslverrR;

	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	wire setup   = psel & ~penable;
	wire acc     = psel & penable & preadyR;
	wire wr      = acc & pwrite;
	wire rd      = acc & ~pwrite;
	wire selCtrl = paddr == kscd_pkg::A_CTRL;
	wire selCmd  = paddr == kscd_pkg::A_CMD;
	wire selStat = paddr == kscd_pkg::A_STAT;
	wire selData = paddr == kscd_pkg::A_DATA;
	wire selRsel = paddr == kscd_pkg::A_RSEL;
	wire selDadr = paddr == kscd_pkg::A_DADDR;
	wire mapped  = selCtrl | selCmd | selStat | selData | selRsel | selDadr;
	wire cmdWr   = wr & selCmd;
	wire cf      = cmdWr & (pwdata[kscd_pkg::CMD_CF] | pwdata[kscd_pkg::CMD_CA]);
	wire cd      = cmdWr & (pwdata[kscd_pkg::CMD_CD] | pwdata[kscd_pkg::CMD_CA]);
	wire ei      = cmdWr & pwdata[kscd_pkg::CMD_EI];
	wire dataRd  = rd & selData;
	wire dataWr  = wr & selData;

	// ------------------------------------------------------------
	// Modes
	// ------------------------------------------------------------
	wire [2:0] kmode  = ctrlR[2:0];
	wire sensMode     = kmode[2:1] == kscd_pkg::KM_SENSOR;
	wire strbMode     = kmode[2:1] == kscd_pkg::KM_STROBE;
	wire kbdMode      = ~kmode[2];
	wire nkMode       = kbdMode & kmode[1];
	wire tkMode       = kbdMode & ~kmode[1];
	wire errMode      = nkMode & ctrlR[kscd_pkg::CTRL_EM];
	wire shortMode    = ~ctrlR[kscd_pkg::CTRL_DM];
	wire rightEntry   = ctrlR[kscd_pkg::CTRL_DM + 1];
	wire [3:0] dLast  = shortMode ? kscd_pkg::LAST8 : kscd_pkg::LAST16;
	wire sensAi       = rselR[kscd_pkg::RSEL_AI];

	// ------------------------------------------------------------
	// Key scan decode
	// ------------------------------------------------------------
	wire keyStep      = tickR && keyTickR == 3'(kscd_pkg::KEY_TICKS - 1);
	wire [2:0] row    = keyPosR[5:3];
	wire [2:0] col    = keyPosR[2:0];
	wire closed       = retS2[col];
	wire [1:0] waitK  = waitR[{keyPosR, 1'b0} +: 2];
	wire fresh        = closed & ~pendR[keyPosR] & ~doneR[keyPosR];
	wire nkDecide     = nkMode & keyStep & pendR[keyPosR]
		& waitK == 2'(kscd_pkg::NK_SCANS - 1);
	wire nkPush       = nkDecide & closed;
	wire simErr       = errMode & keyStep & fresh & (|pendR);
	wire atCand       = keyStep && keyPosR == candR;
	wire tkPush       = tkMode && tkR == kscd_pkg::TK_CHECK && atCand && closed
		&& !otherR;
	wire stbRise      = strbMode & stbS2 & ~stbS3;
	wire [7:0] kbdB   = {stbS2, shfS2, keyPosR};

	// ------------------------------------------------------------
	// Queue traffic
	// ------------------------------------------------------------
	wire [7:0] fifoHead;
	wire [3:0] fifoCount;
	wire       fifoFull;
	wire       fifoEmpty;
	wire       dispBusy;
	wire pushTry      = nkPush | tkPush | stbRise;
	wire [7:0] pushB  = stbRise ? retS2 : kbdB;
	wire pushOk       = pushTry & ~fifoFull & ~errLatchR & ~cf;
	wire popOk        = dataRd & ~sensMode & ~fifoEmpty;

	// ------------------------------------------------------------
	// Sensor image
	// ------------------------------------------------------------
	wire [7:0] sensRow = sensRamR[{row, 3'h0} +: 8];
	wire sensWr        = sensMode && keyStep && col == kscd_pkg::COL_LAST && !sensLockR;
	wire sensNew       = sensWr && sensRow != retS2;
	wire scanEnd       = keyStep && keyPosR == kscd_pkg::KEY_LAST;
	wire sensEvt       = sensMode & scanEnd & (sensChgR | sensNew);
	wire sensClr       = sensMode & ((dataRd & ~sensAi) | (ei & sensAi));

	// ------------------------------------------------------------
	// Event request; a set in the same cycle beats any clear
	// ------------------------------------------------------------
	wire evtSet = (pushOk & fifoEmpty) | simErr | sensEvt;
	wire kbdClr = popOk && fifoCount == 4'h1 && !pushOk && !errLatchR;
	wire evtClr = cf | sensClr | kbdClr;

	// ------------------------------------------------------------
	// Read mux
	// ------------------------------------------------------------
	wire seBit         = sensMode ? (|sensRamR) : errLatchR;
	wire [7:0] statW   = {dispBusy, seBit, overR, underR, fifoCount};
	wire [7:0] dataW   = sensMode ? sensRamR[{rselR[2:0], 3'h0} +: 8] : fifoHead;
	wire [7:0] rselW   = {4'h0, rselR};
	wire [7:0] dadrW   = {3'h0, dAiR, dAddrR};
	wire [7:0] rdByte  = selCtrl ? ctrlR : selStat ? statW : selData ? dataW
		: selRsel ? rselW : selDadr ? dadrW : 8'h00;

	assign prdata    = prdataR;
	assign pready    = preadyR;
	assign pslverr   = pslverrR;
	assign scanLines = keyPosR[5:3];
	assign eventReq  = eventReqR;

	// ------------------------------------------------------------
	// Synchronisers, prescaler and scan counter
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		retS1 <= returnLines;
		retS2 <= retS1;
		shfS1 <= shiftIn;
		shfS2 <= shfS1;
		stbS1 <= strobe_modifier_pin;
		stbS2 <= stbS1;
		stbS3 <= stbS2;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			prescR   <= 12'h000;
			tickR    <= 1'b0;
			keyTickR <= 3'h0;
			keyPosR  <= 6'h00;
		end else begin
			tickR  <= prescR == 12'(TICK_CYCLES - 1);
			prescR <= (prescR == 12'(TICK_CYCLES - 1)) ? 12'h000 : prescR + 12'h001;
			if (tickR) begin
				keyTickR <= keyStep ? 3'h0 : keyTickR + 3'h1;
			end
			if (keyStep) begin
				keyPosR <= keyPosR + 6'h01;
			end
		end
	end

	// ------------------------------------------------------------
	// Registers written by software
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			ctrlR  <= kscd_pkg::CTRL_RST;
			rselR  <= 4'h0;
			dAddrR <= 4'h0;
			dAiR   <= 1'b0;
		end else begin
			if (wr && selCtrl) begin
				ctrlR <= pwdata[7:0];
			end
			if (cf) begin
				rselR[2:0] <= 3'h0;
			end else if (wr && selRsel) begin
				rselR <= pwdata[3:0];
			end else if (dataRd && sensMode && sensAi) begin
				rselR[2:0] <= rselR[2:0] + 3'h1;
			end
			if (wr && selDadr) begin
				dAddrR <= pwdata[3:0];
				dAiR   <= pwdata[kscd_pkg::DADDR_AI];
			end else if (dataWr && !dispBusy && dAiR) begin
				dAddrR <= kscd_pkg::wrapInc(dAddrR, dLast);
			end
		end
	end

	// ------------------------------------------------------------
	// N-key debounce, one slot per key visited in scan order
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			pendR <= '0;
			doneR <= '0;
			waitR <= '0;
		end else if (nkMode && keyStep) begin
			if (fresh) begin
				pendR[keyPosR]              <= 1'b1;
				waitR[{keyPosR, 1'b0} +: 2] <= 2'h0;
			end else if (pendR[keyPosR]) begin
				if (nkDecide) begin
					pendR[keyPosR] <= 1'b0;
					doneR[keyPosR] <= closed;
				end else begin
					waitR[{keyPosR, 1'b0} +: 2] <= waitK + 2'h1;
				end
			end else if (!closed) begin
				doneR[keyPosR] <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Two-key rollover; a key released early returns the machine to idle
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			tkR    <= kscd_pkg::TK_IDLE;
			candR  <= 6'h00;
			otherR <= 1'b0;
		end else if (!tkMode) begin
			tkR <= kscd_pkg::TK_IDLE;
		end else if (keyStep) begin
			case (tkR)
				kscd_pkg::TK_IDLE: begin
					if (closed) begin
						candR <= keyPosR;
						tkR   <= kscd_pkg::TK_SKIP;
					end
				end
				kscd_pkg::TK_SKIP: begin
					if (atCand) begin
						otherR <= 1'b0;
						tkR    <= closed ? kscd_pkg::TK_CHECK : kscd_pkg::TK_IDLE;
					end
				end
				kscd_pkg::TK_CHECK: begin
					if (atCand) begin
						otherR <= 1'b0;
						if (!closed) begin
							tkR <= kscd_pkg::TK_IDLE;
						end else if (!otherR) begin
							tkR <= kscd_pkg::TK_HOLD;
						end
					end else if (closed) begin
						otherR <= 1'b1;
					end
				end
				kscd_pkg::TK_HOLD: begin
					if (atCand && !closed) begin
						tkR <= kscd_pkg::TK_IDLE;
					end
				end
				default: begin
					tkR <= kscd_pkg::TK_IDLE;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Sensor RAM, flags and event
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			sensRamR  <= '0;
			sensLockR <= 1'b0;
			sensChgR  <= 1'b0;
			errLatchR <= 1'b0;
			overR     <= 1'b0;
			underR    <= 1'b0;
			eventReqR <= 1'b0;
		end else begin
			if (sensWr) begin
				sensRamR[{row, 3'h0} +: 8] <= retS2;
			end
			sensChgR  <= scanEnd ? 1'b0 : (sensChgR | sensNew);
			sensLockR <= sensEvt | (sensLockR & ~sensClr & ~cf);
			errLatchR <= simErr | (errLatchR & ~cf);
			overR     <= (pushTry & fifoFull & ~errLatchR) | (overR & ~cf);
			underR    <= (dataRd & ~sensMode & fifoEmpty) | (underR & ~cf);
			eventReqR <= evtSet | (eventReqR & ~evtClr);
		end
	end

	// ------------------------------------------------------------
	// APB answer: no wait state; read data leaves a flip-flop loaded in the setup cycle
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			prdataR  <= 32'h0000_0000;
			preadyR  <= 1'b0;
			pslverrR <= 1'b0;
		end else begin
			preadyR  <= setup;
			pslverrR <= setup & ~mapped;
			if (setup) begin
				prdataR <= {24'h00_0000, rdByte};
			end
		end
	end

	// ------------------------------------------------------------
	// Submodules
	// ------------------------------------------------------------
	kscd_fifo uFifo (
		.clk      (clk),
		.rst      (rst),
		.push     (pushOk),
		.pushData (pushB),
		.pop      (popOk),
		.clr      (cf),
		.head     (fifoHead),
		.count    (fifoCount),
		.full     (fifoFull),
		.empty    (fifoEmpty)
	);

	kscd_disp uDisp (
		.clk        (clk),
		.rst        (rst),
		.tick       (tickR),
		.shortMode  (shortMode),
		.rightEntry (rightEntry),
		.wrStb      (dataWr),
		.wrAddr     (dAddrR),
		.wrData     (pwdata[7:0]),
		.clrStb     (cd),
		.clrCode    (pwdata[kscd_pkg::CMD_CODE +: 2]),
		.digitR     (dispDigit),
		.segR       (dispData),
		.busyR      (dispBusy)
	);

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	chk_push_empty_evt: assert property (@(posedge clk) disable iff (rst)
		pushOk && fifoEmpty |=> eventReqR && fifoCount == 4'h1)
		else $error("first queued key did not raise the event");
	chk_full_drop: assert property (@(posedge clk) disable iff (rst)
		pushTry && fifoFull && !errLatchR && !popOk && !cf |=> overR && fifoFull)
		else $error("key into full queue not dropped with overrun");
	chk_err_block: assert property (@(posedge clk) disable iff (rst)
		simErr |=> errLatchR && eventReqR ##1 !pushOk)
		else $error("simultaneous press did not latch error and block");
	chk_err_hold: assert property (@(posedge clk) disable iff (rst)
		errLatchR && !cf |=> errLatchR)
		else $error("error flag dropped without queue clear");
	chk_clear_fifo: assert property (@(posedge clk) disable iff (rst)
		cf && !simErr && !sensEvt |=> !eventReqR && fifoEmpty && rselR[2:0] == 3'h0)
		else $error("queue clear left state behind");
	chk_pop_step: assert property (@(posedge clk) disable iff (rst)
		popOk && !pushOk && !cf |=> fifoCount == $past(fifoCount) - 4'h1)
		else $error("queue read did not advance");
	chk_sensor_copy: assert property (@(posedge clk) disable iff (rst)
		sensWr |=> sensRamR[{$past(row), 3'h0} +: 8] == $past(retS2))
		else $error("sensor row not copied");
	chk_key_format: assert property (@(posedge clk) disable iff (rst)
		pushOk && !stbRise |-> pushB[5:0] == keyPosR && pushB[7] == stbS2)
		else $error("key byte layout wrong");
	chk_nk_still: assert property (@(posedge clk) disable iff (rst)
		nkPush |-> pendR[keyPosR] && waitK == 2'h1 && closed)
		else $error("n-key queued without two-scan check");
	chk_tk_other: assert property (@(posedge clk) disable iff (rst)
		tkPush |-> tkR == kscd_pkg::TK_CHECK && !otherR ##1 tkR == kscd_pkg::TK_HOLD)
		else $error("two-key queued with another key closed");
endmodule : kscd_keypad_ctrl

// *** sim/kscd_matrix.sv ***
// Key matrix model that answers the scan lines with return levels
`timescale 1ns/100ps
module kscd_matrix (
	// Scan side
	input  wire logic [2:0]  scanLines,
	input  wire logic [63:0] keyMask,
	// Return side
	output logic      [7:0]  returnLines
);
	// Closed keys read high only on the row being scanned
	assign returnLines = keyMask[{scanLines, 3'h0} +: 8];
endmodule : kscd_matrix

// *** sim/keypad_scan_display_ctrl_bench.sv ***
// Self-checking bench for the keypad scan and display controller
`timescale 1ns/100ps
module keypad_scan_display_ctrl_bench;
	logic        clk, rst, psel, penable, pwrite, pready, pslverr, err;
	logic        shiftIn, strobePin, eventReq;
	logic [7:0]  paddr, returnLines, dispData;
	logic [31:0] pwdata, prdata, rd;
	logic [2:0]  scanLines;
	logic [3:0]  dispDigit;
	logic [63:0] keyMask;
	int          n_fail, checks, cyc;
	// Short tick keeps a full scan near 2048 clocks
	kscd_keypad_ctrl #(.TICK_CYCLES(4)) u_dut (.clk(clk), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .returnLines(returnLines), .shiftIn(shiftIn),
		.strobe_modifier_pin(strobePin), .scanLines(scanLines), .dispDigit(dispDigit),
		.dispData(dispData), .eventReq(eventReq));
	kscd_matrix u_mat (.scanLines(scanLines), .keyMask(keyMask), .returnLines(returnLines));
	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// Polls status; a stuck count ends in a mismatch, not a hang
	task automatic waitCount(input logic [3:0] c);
		int n;
		n = 0;
		do begin
			apb(1'b0, kscd_pkg::A_STAT, 32'h0);
			n++;
		end while (rd[3:0] !== c && n < 4000);
	endtask : waitCount
	task automatic test_done;
		$display("Checks %0d, mismatches %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : test_done
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 80000) begin
			n_fail++;
			test_done;
		end
	end
	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial begin
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		shiftIn = 1'b0;
		strobePin = 1'b0;
		keyMask = 64'h0;
		n_fail = 0;
		checks = 0;
		cyc = 0;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		apb(1'b0, kscd_pkg::A_CTRL, 32'h0);
		chk("ctrl reset", 32'h08, rd);
		apb(1'b0, 8'h40, 32'h0);
		chk("unmapped", 32'h1, {31'h0, err});
		// Single press at row 2 column 5 with both modifiers high
		shiftIn   <= 1'b1;
		strobePin <= 1'b1;
		keyMask   <= 64'h1 << 21;
		waitCount(4'h1);
		chk("event", 32'h1, {31'h0, eventReq});
		repeat (4500) @(posedge clk);
		waitCount(4'h1);
		chk("once per press", 32'h1, {28'h0, rd[3:0]});
		keyMask <= 64'h0;
		apb(1'b0, kscd_pkg::A_DATA, 32'h0);
		chk("key byte", 32'hD5, rd);
		apb(1'b0, kscd_pkg::A_DATA, 32'h0);
		apb(1'b0, kscd_pkg::A_STAT, 32'h0);
		chk("underrun", 32'h10, rd);
		apb(1'b1, kscd_pkg::A_CMD, 32'h1);
		apb(1'b0, kscd_pkg::A_STAT, 32'h0);
		chk("cleared", 32'h0, rd);
		chk("event low", 32'h0, {31'h0, eventReq});
		// Two keys at once, pressed while row 0 is scanned so order is known
		shiftIn   <= 1'b0;
		strobePin <= 1'b0;
		apb(1'b1, kscd_pkg::A_CTRL, 32'h0A);
		while (scanLines !== 3'h0)
			@(posedge clk);
		keyMask <= (64'h1 << 30) | (64'h1 << 31);
		waitCount(4'h2);
		keyMask <= 64'h0;
		apb(1'b0, kscd_pkg::A_DATA, 32'h0);
		chk("first key", 32'h1E, rd);
		apb(1'b0, kscd_pkg::A_DATA, 32'h0);
		chk("second key", 32'h1F, rd);
		// Strobed capture of a fixed return pattern
		apb(1'b1, kscd_pkg::A_CTRL, 32'h0E);
		keyMask <= {8{8'hA5}};
		apb(1'b0, kscd_pkg::A_STAT, 32'h0);
		chk("empty", 32'h0, rd);
		strobePin <= 1'b1;
		waitCount(4'h1);
		apb(1'b0, kscd_pkg::A_DATA, 32'h0);
		chk("strobe byte", 32'hA5, rd);
		// Nine strobes: eight fill the queue, the ninth overruns
		repeat (9) begin
			strobePin <= 1'b0;
			repeat (4) @(posedge clk);
			strobePin <= 1'b1;
			repeat (4) @(posedge clk);
		end
		apb(1'b0, kscd_pkg::A_STAT, 32'h0);
		chk("full", 32'h28, rd);
		apb(1'b1, kscd_pkg::A_CMD, 32'h1);
		// Error mode: two keys closed at once, the second seen while the first is pending
		keyMask <= 64'h600;
		apb(1'b1, kscd_pkg::A_CTRL, 32'h2A);
		repeat (2200) @(posedge clk);
		apb(1'b0, kscd_pkg::A_STAT, 32'h0);
		chk("error flag", 32'h40, rd);
		chk("error event", 32'h1, {31'h0, eventReq});
		repeat (4200) @(posedge clk);
		apb(1'b0, kscd_pkg::A_STAT, 32'h0);
		chk("error block", 32'h40, rd);
		keyMask <= 64'h0;
		apb(1'b1, kscd_pkg::A_CMD, 32'h1);
		apb(1'b0, kscd_pkg::A_STAT, 32'h0);
		chk("error clear", 32'h0, rd);
		// Sensor image of one closed switch on row 2
		keyMask <= 64'h1 << 17;
		apb(1'b1, kscd_pkg::A_CTRL, 32'h0C);
		repeat (4200) @(posedge clk);
		chk("sensor event", 32'h1, {31'h0, eventReq});
		apb(1'b1, kscd_pkg::A_RSEL, 32'h2);
		apb(1'b0, kscd_pkg::A_DATA, 32'h0);
		chk("sensor row", 32'h02, rd);
		apb(1'b0, kscd_pkg::A_STAT, 32'h0);
		chk("sensor status", 32'h40, rd);
		chk("sensor event low", 32'h0, {31'h0, eventReq});
		// Left entry with auto-step from address 3
		apb(1'b1, kscd_pkg::A_DADDR, 32'h13);
		apb(1'b1, kscd_pkg::A_DATA, 32'h5A);
		apb(1'b1, kscd_pkg::A_DATA, 32'h3C);
		apb(1'b0, kscd_pkg::A_DADDR, 32'h0);
		chk("auto step", 32'h15, rd);
		while (dispDigit !== 4'h4)
			@(posedge clk);
		repeat (2) @(posedge clk);
		chk("left digit", 32'h3C, {24'h0, dispData});
		// Right entry from address zero
		apb(1'b1, kscd_pkg::A_CTRL, 32'h1E);
		apb(1'b1, kscd_pkg::A_DADDR, 32'h10);
		apb(1'b1, kscd_pkg::A_DATA, 32'h11);
		apb(1'b1, kscd_pkg::A_DATA, 32'h22);
		while (dispDigit !== 4'hF)
			@(posedge clk);
		repeat (2) @(posedge clk);
		chk("right digit", 32'h22, {24'h0, dispData});
		apb(1'b1, kscd_pkg::A_CMD, 32'h2);
		apb(1'b0, kscd_pkg::A_STAT, 32'h0);
		chk("display busy", 32'h80, rd);
		test_done;
	end
endmodule : keypad_scan_display_ctrl_bench
